/* File: design/count_clock_prescaler.sv */
// Bus clock prescaler that makes the refresh counter's count enable
`timescale 1ns/1ps
`default_nettype none

module count_clock_prescaler (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [2:0] select_in,
    output logic tick_out
);

    logic [11:0] div_q;
    logic [11:0] mask;
    logic tick_q;

    // ------------------------------------------------------------
    // Divider mask decode
    // ------------------------------------------------------------
    // assumed 1024 step
    always_comb begin
        unique case (select_in)
            3'h1: mask = refresh_timer_pkg::MASK_DIV4;
            3'h2: mask = refresh_timer_pkg::MASK_DIV16;
            3'h3: mask = refresh_timer_pkg::MASK_DIV64;
            3'h4: mask = refresh_timer_pkg::MASK_DIV256;
            3'h5: mask = refresh_timer_pkg::MASK_DIV1024;
            3'h6: mask = refresh_timer_pkg::MASK_DIV2048;
            default: mask = refresh_timer_pkg::MASK_DIV4096;
        endcase
    end

    // ------------------------------------------------------------
    // Free running divider; one tick per divide period
    // ------------------------------------------------------------
    // Free counter is not restarted when the select changes on the fly, so the first period after a change can be short
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            div_q <= 12'h000;
            tick_q <= 1'b0;
        end else begin
            div_q <= div_q + 12'h001;
            tick_q <= (select_in != refresh_timer_pkg::CKS_STOP) && ((div_q & mask) == mask);
        end
    end

    assign tick_out = tick_q;

endmodule : count_clock_prescaler

`default_nettype wire

/* File: design/refresh_timer_pkg.sv */
// Shared constants and types for the refresh timer and address width block
package refresh_timer_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SDRAM_CONTROL = 8'h00;
    localparam logic [7:0] OFS_REFRESH_TIMER_CONTROL_STATUS = 8'h04;
    localparam logic [7:0] OFS_REFRESH_COUNTER = 8'h08;
    localparam logic [7:0] OFS_REFRESH_PERIOD_CONST = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SDC_REFRESH_ON = 11;
    localparam int SDC_REFRESH_KIND = 10;
    localparam int SDC_BANK_ACTIVE = 8;
    localparam int SDC_ROW_LO = 3;
    localparam int SDC_COL_LO = 0;
    localparam int RTC_MATCH_FLAG = 7;
    localparam int RTC_CLOCK_SELECT_LO = 3;
    localparam int RTC_BURST_LO = 0;
    localparam int KEY_LO = 16;
    localparam int IRQ_MATCH = 0;
    localparam int IRQ_DROPPED = 1;

    // ------------------------------------------------------------
    // Key and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] WRITE_KEY = 16'hA55A;
    localparam logic [7:0] RESET_COUNTER = 8'h00;
    localparam logic [7:0] RESET_PERIOD = 8'h00;
    localparam logic [2:0] RESET_CODE3 = 3'h0;
    localparam logic [1:0] RESET_CODE2 = 2'h0;
    localparam logic [1:0] RESET_IRQ = 2'h0;

    // ------------------------------------------------------------
    // Count clock select codes and prescaler masks (divide minus one)
    // ------------------------------------------------------------
    localparam logic [2:0] CKS_STOP = 3'h0;
    localparam logic [11:0] MASK_DIV4 = 12'h003;
    localparam logic [11:0] MASK_DIV16 = 12'h00F;
    localparam logic [11:0] MASK_DIV64 = 12'h03F;
    localparam logic [11:0] MASK_DIV256 = 12'h0FF;
    localparam logic [11:0] MASK_DIV1024 = 12'h3FF;
    localparam logic [11:0] MASK_DIV2048 = 12'h7FF;
    localparam logic [11:0] MASK_DIV4096 = 12'hFFF;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RS_IDLE,
        RS_PENDING,
        RS_SELF
    } refresh_state_e;

    // One register bus access as seen in a cycle
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    // Whole state of the main module
    typedef struct packed {
        logic refresh_on;
        logic refresh_kind;
        logic bank_active;
        logic [1:0] row_code;
        logic [1:0] col_code;
        logic match_flag;
        logic flag_seen;
        logic [2:0] clock_select;
        logic [2:0] burst_code;
        logic [7:0] counter;
        logic [7:0] period;
        refresh_state_e rstate;
        logic [3:0] burst_len;
        logic [1:0] irq_status;
        logic [1:0] irq_enable;
        logic irq;
        logic req;
        logic self_ref;
        logic [3:0] row_bits;
        logic [3:0] col_bits;
        logic [31:0] rdata;
    } state_s;

endpackage : refresh_timer_pkg

/* File: design/sdram_refresh_timer_config.sv */
// Area three address widths, refresh timer registers and refresh request
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module sdram_refresh_timer_config (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic refresh_done_in,
    output logic [31:0] rdata_out,
    output logic irq_out,
    output logic refresh_req_out,
    output logic [3:0] refresh_burst_out,
    output logic self_refresh_out,
    output logic bank_active_out,
    output logic [3:0] row_bits_out,
    output logic [3:0] col_bits_out
);

    // ------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------
    refresh_timer_pkg::state_s q;
    refresh_timer_pkg::state_s d;
    refresh_timer_pkg::bus_req_s bus;
    logic tick;
    logic match;
    logic key_ok;
    logic wr_sdc;
    logic wr_rtc;
    logic wr_cnt;
    logic wr_cor;
    logic flag_clear;
    logic dropped;
    logic [1:0] irq_events;

    // Gather the bus signals into one carrier
    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    // ------------------------------------------------------------
    // Count clock prescaler
    // ------------------------------------------------------------
    count_clock_prescaler u_prescaler (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .select_in(q.clock_select),
        .tick_out(tick)
    );

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // key guards timer writes
    assign key_ok = bus.wdata[31:refresh_timer_pkg::KEY_LO] == refresh_timer_pkg::WRITE_KEY;
    assign wr_sdc = bus.wr && (bus.addr == refresh_timer_pkg::OFS_SDRAM_CONTROL);
    assign wr_rtc = bus.wr && key_ok
        && (bus.addr == refresh_timer_pkg::OFS_REFRESH_TIMER_CONTROL_STATUS);
    assign wr_cnt = bus.wr && key_ok
        && (bus.addr == refresh_timer_pkg::OFS_REFRESH_COUNTER);
    assign wr_cor = bus.wr && key_ok
        && (bus.addr == refresh_timer_pkg::OFS_REFRESH_PERIOD_CONST);

    assign match = tick && (q.counter == q.period);

    // clear needs prior read of one
    assign flag_clear = wr_rtc && !bus.wdata[refresh_timer_pkg::RTC_MATCH_FLAG] && q.flag_seen;

    assign dropped = match && (q.rstate == refresh_timer_pkg::RS_PENDING) && q.refresh_on
        && !q.refresh_kind;

    // Interrupt events by bit position
    always_comb begin
        irq_events = 2'h0;
        irq_events[refresh_timer_pkg::IRQ_MATCH] = match;
        irq_events[refresh_timer_pkg::IRQ_DROPPED] = dropped;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;

        // Control register; unused bits are simply not stored
        if (wr_sdc) begin
            d.refresh_on = bus.wdata[refresh_timer_pkg::SDC_REFRESH_ON];
            d.refresh_kind = bus.wdata[refresh_timer_pkg::SDC_REFRESH_KIND];
            d.bank_active = bus.wdata[refresh_timer_pkg::SDC_BANK_ACTIVE];
            d.row_code = bus.wdata[refresh_timer_pkg::SDC_ROW_LO +: 2];
            d.col_code = bus.wdata[refresh_timer_pkg::SDC_COL_LO +: 2];
        end

        // Timer control fields
        if (wr_rtc) begin
            d.clock_select = bus.wdata[refresh_timer_pkg::RTC_CLOCK_SELECT_LO +: 3];
            d.burst_code = bus.wdata[refresh_timer_pkg::RTC_BURST_LO +: 3];
        end

        if (wr_cnt) begin
            d.counter = bus.wdata[7:0];
        end else if (match) begin
            d.counter = 8'h00;
        end else if (tick) begin
            d.counter = q.counter + 8'h01;
        end

        if (wr_cor) begin
            d.period = bus.wdata[7:0];
        end

        d.match_flag = (q.match_flag && !flag_clear) || match;

        // arm on a read that shows one, else disarm on any keyed status write
        if (bus.rd && (bus.addr == refresh_timer_pkg::OFS_REFRESH_TIMER_CONTROL_STATUS)
            && q.match_flag) begin
            d.flag_seen = 1'b1;
        end else if (wr_rtc) begin
            d.flag_seen = 1'b0;
        end

        // Refresh request sequencing
        unique case (q.rstate)
            refresh_timer_pkg::RS_IDLE: begin
                if (q.refresh_on && q.refresh_kind) begin
                    d.rstate = refresh_timer_pkg::RS_SELF;
                end else if (q.refresh_on && match) begin
                    d.rstate = refresh_timer_pkg::RS_PENDING;
                end
            end
            refresh_timer_pkg::RS_PENDING: begin
                if (!q.refresh_on) begin
                    d.rstate = refresh_timer_pkg::RS_IDLE;
                end else if (q.refresh_kind) begin
                    d.rstate = refresh_timer_pkg::RS_SELF;
                end else if (!match && refresh_done_in) begin
                    d.rstate = refresh_timer_pkg::RS_IDLE;
                end
            end
            refresh_timer_pkg::RS_SELF: begin
                if (!(q.refresh_on && q.refresh_kind)) begin
                    d.rstate = refresh_timer_pkg::RS_IDLE;
                end
            end
            default: begin
                d.rstate = refresh_timer_pkg::RS_IDLE;
            end
        endcase

        // burst length latched with each new request
        if (match && q.refresh_on && !q.refresh_kind) begin
            unique case (q.burst_code)
                3'h1: d.burst_len = 4'h2;
                3'h2: d.burst_len = 4'h4;
                3'h3: d.burst_len = 4'h6;
                3'h4: d.burst_len = 4'h8;
                // reserved codes fall back to one
                default: d.burst_len = 4'h1;
            endcase
        end

        // Interrupt status: write one to clear, set wins
        if (bus.wr && (bus.addr == refresh_timer_pkg::OFS_IRQ_CLEAR)) begin
            d.irq_status = q.irq_status & ~bus.wdata[1:0];
        end
        d.irq_status = d.irq_status | irq_events;
        if (bus.wr && (bus.addr == refresh_timer_pkg::OFS_IRQ_ENABLE)) begin
            d.irq_enable = bus.wdata[1:0];
        end
        d.irq = |(d.irq_status & d.irq_enable);

        // Registered outputs follow the next state
        d.req = d.rstate == refresh_timer_pkg::RS_PENDING;
        d.self_ref = d.rstate == refresh_timer_pkg::RS_SELF;

        unique case (d.row_code)
            2'h1: d.row_bits = 4'hC;
            2'h2: d.row_bits = 4'hD;
            default: d.row_bits = 4'hB;
        endcase

        unique case (d.col_code)
            2'h1: d.col_bits = 4'h9;
            2'h2: d.col_bits = 4'hA;
            default: d.col_bits = 4'h8;
        endcase

        // Read data for the next cycle only; unmapped reads return zero
        d.rdata = 32'h0000_0000;
        if (bus.rd) begin
            unique case (bus.addr)
                refresh_timer_pkg::OFS_SDRAM_CONTROL: begin
                    // bit 2 and other spares read zero
                    d.rdata[refresh_timer_pkg::SDC_REFRESH_ON] = q.refresh_on;
                    d.rdata[refresh_timer_pkg::SDC_REFRESH_KIND] = q.refresh_kind;
                    d.rdata[refresh_timer_pkg::SDC_BANK_ACTIVE] = q.bank_active;
                    d.rdata[refresh_timer_pkg::SDC_ROW_LO +: 2] = q.row_code;
                    d.rdata[refresh_timer_pkg::SDC_COL_LO +: 2] = q.col_code;
                end
                refresh_timer_pkg::OFS_REFRESH_TIMER_CONTROL_STATUS: begin
                    d.rdata[refresh_timer_pkg::RTC_MATCH_FLAG] = q.match_flag;
                    d.rdata[refresh_timer_pkg::RTC_CLOCK_SELECT_LO +: 3] = q.clock_select;
                    d.rdata[refresh_timer_pkg::RTC_BURST_LO +: 3] = q.burst_code;
                end
                refresh_timer_pkg::OFS_REFRESH_COUNTER: begin
                    d.rdata[7:0] = q.counter;
                end
                refresh_timer_pkg::OFS_REFRESH_PERIOD_CONST: begin
                    d.rdata[7:0] = q.period;
                end
                refresh_timer_pkg::OFS_IRQ_STATUS: begin
                    d.rdata[1:0] = q.irq_status;
                end
                refresh_timer_pkg::OFS_IRQ_ENABLE: begin
                    d.rdata[1:0] = q.irq_enable;
                end
                default: begin
                    d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            q.refresh_on <= 1'b0;
            q.refresh_kind <= 1'b0;
            q.bank_active <= 1'b0;
            q.row_code <= refresh_timer_pkg::RESET_CODE2;
            q.col_code <= refresh_timer_pkg::RESET_CODE2;
            q.match_flag <= 1'b0;
            q.flag_seen <= 1'b0;
            q.clock_select <= refresh_timer_pkg::RESET_CODE3;
            q.burst_code <= refresh_timer_pkg::RESET_CODE3;
            q.counter <= refresh_timer_pkg::RESET_COUNTER;
            q.period <= refresh_timer_pkg::RESET_PERIOD;
            q.rstate <= refresh_timer_pkg::RS_IDLE;
            q.burst_len <= 4'h1;
            q.irq_status <= refresh_timer_pkg::RESET_IRQ;
            q.irq_enable <= refresh_timer_pkg::RESET_IRQ;
            q.irq <= 1'b0;
            q.req <= 1'b0;
            q.self_ref <= 1'b0;
            q.row_bits <= 4'hB;
            q.col_bits <= 4'h8;
            q.rdata <= 32'h0000_0000;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------
    assign rdata_out = q.rdata;
    assign irq_out = q.irq;
    assign refresh_req_out = q.req;
    assign refresh_burst_out = q.burst_len;
    assign self_refresh_out = q.self_ref;
    assign bank_active_out = q.bank_active;
    assign row_bits_out = q.row_bits;
    assign col_bits_out = q.col_bits;

endmodule : sdram_refresh_timer_config

`default_nettype wire

/* File: test/refresh_sequencer_model.sv */
// Model of the refresh sequencer that answers refresh requests
`timescale 1ns/1ps
`default_nettype none

module refresh_sequencer_model (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic req_in,
    input wire logic [3:0] delay_in,
    input wire logic hold_in,
    output logic done_out
);
    logic [3:0] wait_q;
    logic [1:0] cool_q;

    // answers held request
    // Cool-down keeps a stale request from being acknowledged twice
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wait_q <= 4'h0;
            cool_q <= 2'h0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (cool_q != 2'h0) begin
                cool_q <= cool_q - 2'h1;
            end else if (req_in && !hold_in) begin
                if (wait_q == delay_in) begin
                    done_out <= 1'b1;
                    wait_q <= 4'h0;
                    cool_q <= 2'h3;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
        end
    end
endmodule : refresh_sequencer_model

`default_nettype wire

/* File: test/refresh_timer_sva.sv */
// Port-level checker for the refresh timer and address width block
`timescale 1ns/1ps
`default_nettype none

module refresh_timer_chk (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic refresh_done_in,
    input wire logic [31:0] rdata_out,
    input wire logic irq_out,
    input wire logic refresh_req_out,
    input wire logic [3:0] refresh_burst_out,
    input wire logic self_refresh_out,
    input wire logic bank_active_out,
    input wire logic [3:0] row_bits_out,
    input wire logic [3:0] col_bits_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    // ------------------------------------------------------------
    // Read data of reserved bits
    // ------------------------------------------------------------
    status_upper_a: assert property (
        rd_in && addr_in == 8'h04 |=> rdata_out[31:8] == 24'h0)
        else $error("status upper bits not zero");
    status_bit6_a: assert property (
        rd_in && addr_in == 8'h04 |=> !rdata_out[6])
        else $error("status bit 6 not zero");
    ctrl_bit2_a: assert property (
        rd_in && addr_in == 8'h00 |=> !rdata_out[2])
        else $error("control bit 2 not zero");

    // ------------------------------------------------------------
    // Decoded widths and burst length
    // ------------------------------------------------------------
    row_legal_a: assert property (row_bits_out inside {4'hB, 4'hC, 4'hD})
        else $error("row width out of range");
    col_legal_a: assert property (col_bits_out inside {4'h8, 4'h9, 4'hA})
        else $error("column width out of range");
    burst_legal_a: assert property (
        refresh_burst_out inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8})
        else $error("burst length out of range");
    // Widths are allowed three cycles to settle so either output stage depth passes
    width_follow_a: assert property (
        wr_in && addr_in == 8'h00 && wdata_in[4:3] != 2'h3 && wdata_in[1:0] != 2'h3
        ##1 !wr_in ##1 !wr_in |=> row_bits_out == 4'hB + {2'h0, $past(wdata_in[4:3], 3)}
        && col_bits_out == 4'h8 + {2'h0, $past(wdata_in[1:0], 3)})
        else $error("width outputs do not follow control write");

    // ------------------------------------------------------------
    // Refresh request and self refresh
    // ------------------------------------------------------------
    req_hold_a: assert property (
        refresh_req_out && !refresh_done_in && !$past(refresh_done_in)
        && !wr_in && !$past(wr_in) |=> refresh_req_out)
        else $error("request dropped without done");
    req_release_a: assert property (
        refresh_req_out && refresh_done_in |=> !refresh_req_out)
        else $error("request not released after done");
    self_start_a: assert property (
        wr_in && addr_in == 8'h00 && wdata_in[11:10] == 2'h3 |-> ##2 self_refresh_out)
        else $error("self refresh did not start");
endmodule : refresh_timer_chk

bind sdram_refresh_timer_config refresh_timer_chk u_chk (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .refresh_done_in(refresh_done_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .refresh_req_out(refresh_req_out), .refresh_burst_out(refresh_burst_out),
    .self_refresh_out(self_refresh_out), .bank_active_out(bank_active_out),
    .row_bits_out(row_bits_out), .col_bits_out(col_bits_out));

`default_nettype wire

/* File: test/sdram_refresh_timer_config_tb_top.sv */
// Self-checking bench for the refresh timer and address width block
`timescale 1ns/1ps
`default_nettype none

module sdram_refresh_timer_config_tb_top;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic done;
    logic [3:0] dly = 4'h0;
    logic hold = 1'b0;
    logic [31:0] rdata, v;
    logic irq, req, self_ref, bank;
    logic [3:0] burst, row_b, col_b;
    int num_errors = 0;
    int checks_done = 0;
    int n;
    // Rows: control word written, readback, {bank, row width, column width}
    logic [31:0] row_w [6] = '{32'h0, 32'h9, 32'h12, 32'h1, 32'h8, 32'h106};
    logic [31:0] row_r [6] = '{32'h0, 32'h9, 32'h12, 32'h1, 32'h8, 32'h102};
    logic [8:0] row_o [6] = '{9'h0B8, 9'h0C9, 9'h0DA, 9'h0B9, 9'h0C8, 9'h1BA};
    logic [3:0] bursts [5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8};
    int divs [7] = '{4, 16, 64, 256, 1024, 2048, 4096};

    // 125 MHz bus clock
    always #4 core_clk_in = ~core_clk_in;

    sdram_refresh_timer_config u_sdram_refresh_timer_config (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .refresh_done_in(done), .rdata_out(rdata),
        .irq_out(irq), .refresh_req_out(req), .refresh_burst_out(burst),
        .self_refresh_out(self_ref), .bank_active_out(bank), .row_bits_out(row_b),
        .col_bits_out(col_b));

    refresh_sequencer_model u_refresh_sequencer_model (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req), .delay_in(dly),
        .hold_in(hold), .done_out(done));

    // ------------------------------------------------------------
    // Bus cycles, comparison and closing report
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask : wr_reg

    // Data stands only in the cycle after the read edge
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Counts edges up to the next rising request, bounded
    task automatic wait_rise(output int cnt);
        logic prev;
        cnt = 0;
        prev = req;
        while (!(!prev && req)) begin
            prev = req;
            @(posedge core_clk_in);
            #1 cnt++;
            if (cnt > 20000) begin
                num_errors++;
                tally_and_finish();
            end
        end
    endtask : wait_rise

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge core_clk_in);
        rst_in <= 1'b0;
        #1 chk({16'h0, irq, req, self_ref, bank, burst, row_b, col_b}, 32'h01B8);
        rd_reg(8'h04, v);
        chk(v, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            wr_reg(8'h00, row_w[i]);
            repeat (3) @(posedge core_clk_in);
            #1 chk({23'h0, bank, row_b, col_b}, {23'h0, row_o[i]});
            rd_reg(8'h00, v);
            chk(v, row_r[i]);
        end
        $display("test widths done");
        // Keyless write ignored, keyed write keeps only writable bits
        wr_reg(8'h04, 32'h0000_003F);
        rd_reg(8'h04, v);
        chk(v, 32'h0);
        wr_reg(8'h04, 32'hA55A_FFCC);
        rd_reg(8'h04, v);
        chk(v, 32'h0000_000C);
        rd_reg(8'hFC, v);
        chk(v, 32'h0);
        $display("test key done");
        // Period one, divide by four, slow sequencer
        wr_reg(8'h0C, 32'hA55A_0001);
        wr_reg(8'h00, 32'h800);
        dly <= 4'h2;
        for (int i = 0; i < 5; i++) begin
            // Only the documented burst codes are programmed
            wr_reg(8'h04, 32'hA55A_0008 | 32'(i));
            wait_rise(n);
            wait_rise(n);
            chk({28'h0, burst}, {28'h0, bursts[i]});
        end
        $display("test burst done");
        // Zero without a prior read of one leaves the flag set
        wr_reg(8'h04, 32'hA55A_0000);
        rd_reg(8'h04, v);
        chk(v, 32'h80);
        wr_reg(8'h04, 32'hA55A_0000);
        rd_reg(8'h04, v);
        chk(v, 32'h0);
        wr_reg(8'h08, 32'hA55A_0005);
        wr_reg(8'h08, 32'h0000_0007);
        repeat (50) @(posedge core_clk_in);
        rd_reg(8'h08, v);
        chk(v, 32'h5);
        $display("test flag done");
        // Request spacing is two ticks of the count clock with period one
        dly <= 4'h0;
        for (int i = 0; i < 7; i++) begin
            wr_reg(8'h04, 32'hA55A_0000 | 32'((i + 1) << 3));
            wr_reg(8'h08, 32'hA55A_0000);
            wait_rise(n);
            wait_rise(n);
            chk(32'(n), 32'(2 * divs[i]));
        end
        $display("test divide done");
        // Sequencer stalls so a newer match replaces the pending request
        wr_reg(8'h18, 32'h3);
        hold <= 1'b1;
        wr_reg(8'h04, 32'hA55A_0008);
        wr_reg(8'h08, 32'hA55A_0000);
        repeat (40) @(posedge core_clk_in);
        wr_reg(8'h04, 32'hA55A_0000);
        rd_reg(8'h10, v);
        chk(v, 32'h3);
        chk({31'h0, irq}, 32'h1);
        wr_reg(8'h18, 32'h0);
        repeat (2) @(posedge core_clk_in);
        #1 chk({31'h0, irq}, 32'h0);
        wr_reg(8'h18, 32'h3);
        repeat (2) @(posedge core_clk_in);
        #1 chk({31'h0, irq}, 32'h1);
        wr_reg(8'h14, 32'h3);
        repeat (2) @(posedge core_clk_in);
        #1 chk({30'h0, irq, req}, 32'h1);
        // Release the stalled sequencer right on an edge
        @(posedge core_clk_in);
        hold <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        #1 chk({31'h0, req}, 32'h0);
        $display("test drop done");
        wr_reg(8'h00, 32'hC00);
        repeat (2) @(posedge core_clk_in);
        #1 chk({31'h0, self_ref}, 32'h1);
        wr_reg(8'h00, 32'h0);
        repeat (3) @(posedge core_clk_in);
        #1 chk({31'h0, self_ref}, 32'h0);
        $display("test self done");
        tally_and_finish();
    end
endmodule : sdram_refresh_timer_config_tb_top

`default_nettype wire
